//--- verilog/hbi_map.svh
// Purpose: Offsets, field positions, reset values and timing counts.
// Assumes: System clock of 4 ns.
// Notes:   Definitions only.
`ifndef HBI_MAP_SVH
`define HBI_MAP_SVH

`define HBI_MCLK_NS       4
`define HBI_EE_PERIOD_NS  4000
`define HBI_EE_HALF_CYC   (`HBI_EE_PERIOD_NS / (2 * `HBI_MCLK_NS))
`define HBI_EE_CNT_W      10
`define HBI_EE_CMD_BITS   5'h09
`define HBI_EE_TOTAL_BITS 5'h19
`define HBI_EE_CMD_WORD   16'hc000
`define HBI_BASE_RST      16'h0300
`define HBI_STRAP_SETTLE  2'h2

`define HBI_PIN_N     8
`define HBI_PIN_RD    0
`define HBI_PIN_WR    1
`define HBI_PIN_ADS   2
`define HBI_PIN_MODE  3
`define HBI_PIN_ROMEN 4
`define HBI_PIN_SI    5
`define HBI_PIN_CYC   6
`define HBI_PIN_TOG   7
// Strobe bits rest high so that no false edge follows reset.
`define HBI_PIN_IDLE  8'h07

`endif

//--- verilog/hbi_pkg.sv
// Purpose: Types shared by the host port and the configuration loader.
// Assumes: hbi_map.svh supplies the widths.
// Notes:   None.
`include "hbi_map.svh"
package hbi_pkg;

	typedef enum logic [1:0]
	{
		HBI_W8  = 2'b00,
		HBI_W16 = 2'b01,
		HBI_W32 = 2'b10
	} hbi_width_e;

	typedef enum logic [1:0]
	{
		LD_IDLE  = 2'b00,
		LD_SHIFT = 2'b01,
		LD_DONE  = 2'b10
	} hbi_ld_e;

	typedef struct packed
	{
		hbi_ld_e                  state;
		logic [`HBI_EE_CNT_W-1:0] halfCnt;
		logic [4:0]               bitCnt;
		logic [15:0]              shift;
		logic                     sclk;
		logic                     cs;
		logic                     sout;
		logic                     done;
	} hbi_ld_s;

	typedef struct packed
	{
		logic [`HBI_PIN_N-1:0] pinS1;
		logic [`HBI_PIN_N-1:0] pinS2;
		logic [15:1]           addrS1;
		logic [15:1]           addrS2;
		logic                  aenS1;
		logic                  aenS2;
		logic [15:1]           latAddr;
		logic                  latAen;
		logic [1:0]            strapCnt;
		logic                  strapDone;
		logic                  busSync;
		hbi_width_e            width;
		logic                  romEn;
		logic [15:0]           baseAddr;
		logic                  irqOeN;
		logic                  ardyOeN;
		logic                  accBusy;
		logic                  accReq;
		logic                  accWrite;
		logic                  accSync;
		logic                  loadGo;
		logic                  rdPrev;
		logic                  wrPrev;
		logic                  adsPrev;
		logic                  togPrev;
	} hbi_core_s;

	typedef struct packed
	{
		logic modeS1;
		logic modeS2;
		logic tog;
		logic dir;
	} hbi_link_s;

endpackage

//--- verilog/hbi_rom_if.sv
// Purpose: Carries the loader request and serial pins between modules.
// Assumes: Both ends run on the system clock.
// Notes:   None.
`timescale 1ns/1ps
interface hbi_rom_if;
	logic        start;
	logic        serialIn;
	logic        sclk;
	logic        cs;
	logic        sout;
	logic        done;
	logic [15:0] word;

	modport core   (output start, serialIn, input sclk, cs, sout, done, word);
	modport loader (input start, serialIn, output sclk, cs, sout, done, word);
endinterface

//--- verilog/hbi_cfg_loader.sv
// Purpose: Reads one configuration word from a serial EEPROM.
// Assumes: serialIn is already synchronised to mclk.
// Notes:   The 16 data bits are captured straight after the 9 command bits.
`timescale 1ns/1ps
`include "hbi_map.svh"
module hbi_cfg_loader
	import hbi_pkg::*;
#(
	parameter int unsigned HALF_CYC = `HBI_EE_HALF_CYC
)
(
	input wire logic   mclk, // System clock.
	input wire logic   nrst, // Asynchronous reset, active low.
	input wire logic   ce,   // Clock enable.
	hbi_rom_if.loader  rif   // Request and serial pins.
);
	localparam hbi_ld_s LD_RST = '{state: LD_IDLE, default: '0};
	localparam logic [`HBI_EE_CNT_W-1:0] HALF_LAST =
		`HBI_EE_CNT_W'(HALF_CYC - 1);

	hbi_ld_s ldReg;
	hbi_ld_s ldNext;

	always_comb
	begin
		ldNext = ldReg;
		ldNext.done = 1'b0;
		case (ldReg.state)
		LD_IDLE:
		begin
			if (rif.start)
			begin
				ldNext.state = LD_SHIFT;
				ldNext.cs = 1'b1;
				ldNext.sclk = 1'b0;
				ldNext.halfCnt = '0;
				ldNext.bitCnt = '0;
				ldNext.shift = `HBI_EE_CMD_WORD;
				ldNext.sout = ldNext.shift[15];
			end
		end
		LD_SHIFT:
		begin
			if (ldReg.halfCnt == HALF_LAST)
			begin
				ldNext.halfCnt = '0;
				ldNext.sclk = !ldReg.sclk;
				if (!ldReg.sclk)
				begin
					if (ldReg.bitCnt >= `HBI_EE_CMD_BITS)
						ldNext.shift = {ldReg.shift[14:0], rif.serialIn};
				end
				else if (ldReg.bitCnt == `HBI_EE_TOTAL_BITS - 5'h01)
				begin
					ldNext.state = LD_DONE;
					ldNext.cs = 1'b0;
					ldNext.sout = 1'b0;
				end
				else
				begin
					ldNext.bitCnt = ldReg.bitCnt + 5'h01;
					if (ldNext.bitCnt < `HBI_EE_CMD_BITS)
					begin
						ldNext.shift = {ldReg.shift[14:0], 1'b0};
						ldNext.sout = ldNext.shift[15];
					end
					else
						ldNext.sout = 1'b0;
				end
			end
			else
				ldNext.halfCnt = ldReg.halfCnt + `HBI_EE_CNT_W'h001;
		end
		LD_DONE:
		begin
			ldNext.done = 1'b1;
			ldNext.state = LD_IDLE;
		end
		default:
			ldNext = LD_RST;
		endcase
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			ldReg <= LD_RST;
		else if (ce)
			ldReg <= ldNext;
	end

	assign rif.sclk = ldReg.sclk;
	assign rif.cs = ldReg.cs;
	assign rif.sout = ldReg.sout;
	assign rif.done = ldReg.done;
	assign rif.word = ldReg.shift;

	sequence ld_start_s;
		ce && ldReg.state == LD_IDLE && rif.start;
	endsequence

	load_start_a:
	assert property (@(posedge mclk) disable iff (!nrst)
		ld_start_s |=> rif.cs && rif.sout && !rif.sclk)
		else $error("Loader did not open the transfer correctly.");

	select_span_a:
	assert property (@(posedge mclk) disable iff (!nrst)
		rif.cs |-> ldReg.state == LD_SHIFT)
		else $error("Chip select active outside a transfer.");

	sclk_half_a:
	assert property (@(posedge mclk) disable iff (!nrst)
		ce && ldReg.state == LD_SHIFT && ldReg.halfCnt != HALF_LAST
		|=> $stable(rif.sclk))
		else $error("Serial clock toggled before the half period.");
endmodule

//--- verilog/hbi_host_port.sv
// Purpose: Host bus port: device select, strobes, ready, straps, loader.
// Assumes: busClk runs only in synchronous bus mode.
// Notes:   localDevSelectN is combinational by design.
// What this block does
// - Interrupt pin low while any status set.
// - Select low on qualifier low, address match.
// - Read strobe handled without any bus clock.
// - Ready held low until access completes.
// - Write/read select high writes, low reads.
// - Mode strap low selects synchronous bus.
// - Mode strap high selects asynchronous or burst.
// - EEPROM used only when enable strap high.
// - EEPROM serial clock has 4 us period.
// - Command and address bits shifted to EEPROM.
// - Configuration bits sampled from EEPROM data.
// - Without EEPROM, data pin picks bus width; a 32-bit build (IS_32BIT) always uses 32.
// - Address and qualifier latched on strobe rise.
`timescale 1ns/1ps
`include "hbi_map.svh"
module hbi_host_port
	import hbi_pkg::*;
#(
	parameter bit          IS_32BIT   = 1'b0,
	parameter int unsigned INT_W      = 16,
	parameter logic [15:0] BASE_RESET = `HBI_BASE_RST
)
(
	input  wire logic             mclk,              // System clock.
	input  wire logic             nrst,              // Reset, active low.
	input  wire logic             ce,                // Clock enable.
	input  wire logic             busClk,            // Host bus clock.
	input  wire logic [15:1]      addrIn,            // Address A15-A1.
	input  wire logic             addrQualN,         // Address qualifier.
	input  wire logic             addrStrobeN,       // Address strobe.
	input  wire logic             addrLatchEn,       // Decode latched addr.
	input  wire logic             readStrobeN,       // Read strobe.
	input  wire logic             writeStrobeN,      // Write strobe.
	input  wire logic             cycleNA,           // Cycle signal.
	input  wire logic             syncWriteRead,     // Sync direction.
	input  wire logic             busModeStrap,      // Bus mode strap.
	input  wire logic             cfgRomEnableStrap, // EEPROM enable strap.
	input  wire logic             cfgRomSerialIn,    // EEPROM data in.
	input  wire logic [INT_W-1:0] intStatus,         // Interrupt status.
	input  wire logic             accDone,           // Core finished access.
	input  wire logic             baseAddrWe,        // Base address write.
	input  wire logic [15:0]      baseAddrIn,        // New base address.
	output logic                  localDevSelectN,   // Device selected.
	output logic                  hostIrqO,          // Interrupt pin value.
	output logic                  hostIrqOeN,        // Interrupt pin enable.
	output logic                  asyncReadyO,       // Ready pin value.
	output logic                  asyncReadyOeN,     // Ready pin enable.
	output logic                  cfgRomSelect,      // EEPROM chip select.
	output logic                  cfgRomSerialClk,   // EEPROM clock.
	output logic                  cfgRomSerialOut,   // EEPROM data out.
	output logic                  accReq,            // Access request pulse.
	output logic                  accWrite,          // Access is a write.
	output logic                  accSync,           // Access was synchronous.
	output logic                  cfgBusSync,        // Synchronous bus mode.
	output hbi_width_e            cfgWidth,          // Bus width.
	output logic                  cfgRomPresent,     // EEPROM in use.
	output logic [15:0]           baseAddr           // Programmed base.
);
	localparam hbi_core_s CORE_RST = '{
		pinS1:    `HBI_PIN_IDLE,
		pinS2:    `HBI_PIN_IDLE,
		irqOeN:   1'b1,
		ardyOeN:  1'b1,
		baseAddr: BASE_RESET,
		width:    HBI_W8,
		rdPrev:   1'b1,
		wrPrev:   1'b1,
		adsPrev:  1'b1,
		default:  '0
	};
	localparam hbi_link_s LINK_RST = '{default: '0};

	hbi_core_s coreReg;
	hbi_core_s coreNext;
	hbi_link_s linkReg;
	hbi_link_s linkNext;
	hbi_rom_if romIf ();

	logic [`HBI_PIN_N-1:0] pinRaw;
	logic                  rawHit;
	logic                  selSync;
	logic                  rdFall;
	logic                  wrFall;
	logic                  togEdge;
	logic                  strapTake;
	logic                  burstMode;
	logic                  strobesIdle;

	// Same decode serves the pin and the synchronised access qualifier.
	function automatic logic hbi_hit(
		input logic [15:4] addr,
		input logic        qualN,
		input logic [15:0] base
	);
		hbi_hit = !qualN && (addr == base[15:4]);
	endfunction

	hbi_cfg_loader #(
		.HALF_CYC (`HBI_EE_HALF_CYC)
	) u_loader (
		.mclk (mclk),
		.nrst (nrst),
		.ce   (ce),
		.rif  (romIf)
	);

	assign romIf.start = coreReg.loadGo;
	assign romIf.serialIn = coreReg.pinS2[`HBI_PIN_SI];

	// Combinational decode from the pins, or from the latched address when addrLatchEn is set, as the host expects no latency.
	assign rawHit = addrLatchEn ?
		hbi_hit(coreReg.latAddr[15:4], coreReg.latAen, coreReg.baseAddr) :
		hbi_hit(addrIn[15:4], addrQualN, coreReg.baseAddr);
	assign localDevSelectN = !rawHit;

	assign pinRaw[`HBI_PIN_RD] = readStrobeN;
	assign pinRaw[`HBI_PIN_WR] = writeStrobeN;
	assign pinRaw[`HBI_PIN_ADS] = addrStrobeN;
	assign pinRaw[`HBI_PIN_MODE] = busModeStrap;
	assign pinRaw[`HBI_PIN_ROMEN] = cfgRomEnableStrap;
	assign pinRaw[`HBI_PIN_SI] = cfgRomSerialIn;
	assign pinRaw[`HBI_PIN_CYC] = cycleNA;
	assign pinRaw[`HBI_PIN_TOG] = linkReg.tog;

	assign selSync = addrLatchEn ?
		hbi_hit(coreReg.latAddr[15:4], coreReg.latAen, coreReg.baseAddr) :
		hbi_hit(coreReg.addrS2[15:4], coreReg.aenS2, coreReg.baseAddr);
	assign rdFall = coreReg.rdPrev && !coreReg.pinS2[`HBI_PIN_RD];
	assign wrFall = coreReg.wrPrev && !coreReg.pinS2[`HBI_PIN_WR];
	assign togEdge = coreReg.pinS2[`HBI_PIN_TOG] ^ coreReg.togPrev;
	assign strapTake = !coreReg.strapDone &&
		coreReg.strapCnt == `HBI_STRAP_SETTLE;
	assign burstMode = !coreReg.busSync && coreReg.width == HBI_W32;
	assign strobesIdle = coreReg.pinS2[`HBI_PIN_RD] &&
		coreReg.pinS2[`HBI_PIN_WR];

	always_comb
	begin
		coreNext = coreReg;
		coreNext.pinS1 = pinRaw;
		coreNext.pinS2 = coreReg.pinS1;
		coreNext.addrS1 = addrIn;
		coreNext.addrS2 = coreReg.addrS1;
		coreNext.aenS1 = addrQualN;
		coreNext.aenS2 = coreReg.aenS1;
		coreNext.rdPrev = coreReg.pinS2[`HBI_PIN_RD];
		coreNext.wrPrev = coreReg.pinS2[`HBI_PIN_WR];
		coreNext.adsPrev = coreReg.pinS2[`HBI_PIN_ADS];
		coreNext.togPrev = coreReg.pinS2[`HBI_PIN_TOG];
		coreNext.accReq = 1'b0;
		coreNext.loadGo = 1'b0;

		// Straps wait until both synchroniser stages hold pin levels.
		if (strapTake)
		begin
			coreNext.strapDone = 1'b1;
			coreNext.busSync = !coreReg.pinS2[`HBI_PIN_MODE];
			coreNext.romEn = coreReg.pinS2[`HBI_PIN_ROMEN];
			coreNext.loadGo = coreReg.pinS2[`HBI_PIN_ROMEN];
			if (IS_32BIT)
				coreNext.width = HBI_W32;
			else if (coreReg.pinS2[`HBI_PIN_ROMEN] ||
				coreReg.pinS2[`HBI_PIN_SI])
				coreNext.width = HBI_W16;
			else
				coreNext.width = HBI_W8;
		end
		else if (!coreReg.strapDone)
			coreNext.strapCnt = coreReg.strapCnt + 2'h1;

		coreNext.irqOeN = ~|intStatus;

		// Address and qualifier were sampled alongside the strobe.
		if (!coreReg.adsPrev && coreReg.pinS2[`HBI_PIN_ADS])
		begin
			coreNext.latAddr = coreReg.addrS2;
			coreNext.latAen = coreReg.aenS2;
		end

		// The direction word was stable before its toggle was seen here.
		if (coreReg.busSync && togEdge)
		begin
			coreNext.accReq = 1'b1;
			coreNext.accSync = 1'b1;
			coreNext.accWrite = linkReg.dir;
		end

		// Ready is released when the strobe ends or the core finishes.
		if (accDone || strobesIdle)
			coreNext.accBusy = 1'b0;
		if (!coreReg.busSync && (rdFall || wrFall) && selSync)
		begin
			coreNext.accReq = 1'b1;
			coreNext.accSync = 1'b0;
			coreNext.accBusy = 1'b1;
			if (burstMode)
				coreNext.accWrite = !coreReg.pinS2[`HBI_PIN_CYC];
			else
				coreNext.accWrite = wrFall;
		end
		coreNext.ardyOeN = !coreNext.accBusy;

		if (romIf.done)
			coreNext.baseAddr = romIf.word;
		if (baseAddrWe)
			coreNext.baseAddr = baseAddrIn;
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			coreReg <= CORE_RST;
		else if (ce)
			coreReg <= coreNext;
	end

	// Link side: host signals here are synchronous to busClk.
	always_comb
	begin
		linkNext = linkReg;
		linkNext.modeS1 = coreReg.busSync;
		linkNext.modeS2 = linkReg.modeS1;
		if (linkReg.modeS2 && !cycleNA && rawHit)
		begin
			linkNext.tog = !linkReg.tog;
			linkNext.dir = syncWriteRead;
		end
	end

	always_ff @(posedge busClk or negedge nrst)
	begin
		if (!nrst)
			linkReg <= LINK_RST;
		else
			linkReg <= linkNext;
	end

	assign hostIrqO = 1'b0;
	assign hostIrqOeN = coreReg.irqOeN;
	assign asyncReadyO = 1'b0;
	assign asyncReadyOeN = coreReg.ardyOeN;
	assign cfgRomSelect = romIf.cs;
	assign cfgRomSerialClk = romIf.sclk;
	assign cfgRomSerialOut = romIf.sout;
	assign accReq = coreReg.accReq;
	assign accWrite = coreReg.accWrite;
	assign accSync = coreReg.accSync;
	assign cfgBusSync = coreReg.busSync;
	assign cfgWidth = coreReg.width;
	assign cfgRomPresent = coreReg.romEn;
	assign baseAddr = coreReg.baseAddr;

	sequence read_fall_s;
		ce && !coreReg.busSync && !burstMode && rdFall && selSync &&
			coreReg.pinS2[`HBI_PIN_WR];
	endsequence

	irq_assert_a:
	assert property (@(posedge mclk) disable iff (!nrst)
		ce && (|intStatus) |=> !hostIrqOeN)
		else $error("Interrupt pin not driven with status set.");

	irq_release_a:
	assert property (@(posedge mclk) disable iff (!nrst)
		ce && !(|intStatus) |=> hostIrqOeN)
		else $error("Interrupt pin driven with no status set.");

	qual_block_a:
	assert property (@(posedge mclk) disable iff (!nrst)
		!addrLatchEn && addrQualN |-> localDevSelectN)
		else $error("Device selected while qualifier high.");

	sel_match_a:
	assert property (@(posedge mclk) disable iff (!nrst)
		!addrLatchEn && !localDevSelectN
		|-> addrIn[15:4] == baseAddr[15:4])
		else $error("Device selected on a foreign address.");

	read_ready_a:
	assert property (@(posedge mclk) disable iff (!nrst)
		read_fall_s |=> accReq && !accWrite && !asyncReadyOeN)
		else $error("Read not requested or ready not held.");

	strap_mode_a:
	assert property (@(posedge mclk) disable iff (!nrst)
		ce && strapTake
		|=> cfgBusSync == !$past(coreReg.pinS2[`HBI_PIN_MODE]))
		else $error("Bus mode does not follow the strap.");

	strap_hold_a:
	assert property (@(posedge mclk) disable iff (!nrst)
		coreReg.strapDone |=> $stable(cfgBusSync) && $stable(cfgWidth)
			&& $stable(cfgRomPresent))
		else $error("Strap configuration changed after capture.");

	rom_gate_a:
	assert property (@(posedge mclk) disable iff (!nrst)
		!cfgRomPresent |-> !cfgRomSelect)
		else $error("EEPROM selected while disabled.");

	sync_dir_a:
	assert property (@(posedge mclk) disable iff (!nrst)
		ce && coreReg.busSync && togEdge
		|=> accReq && accSync && accWrite == $past(linkReg.dir))
		else $error("Synchronous access direction lost.");
endmodule

//--- bench/hbi_far_model.sv
// Purpose: Host bus clock, synchronous commands and a serial EEPROM.
// Assumes: Bus clock period of 125 ns, running only in synchronous mode.
// Notes:   The EEPROM returns ROM_WORD, most significant bit first.
`timescale 1ns/1ps
module hbi_far_model
#(
	parameter logic [15:0] ROM_WORD = 16'ha5c0
)
(
	input  wire logic  busRun,   // Run the bus clock.
	input  wire logic  strapLvl, // Width strap level.
	input  wire logic  romSel,   // EEPROM chip select.
	input  wire logic  romClk,   // EEPROM serial clock.
	input  wire logic  romDin,   // Bits from the device.
	output logic       busClk,   // Host bus clock.
	output logic       cycleNA,  // Cycle signal.
	output logic       syncWr,   // Write/read select.
	output logic       romDout,  // Data to the device.
	output logic [8:0] cmdBits   // Command bits seen.
);
	int   risesSeen;
	logic romData;

	initial
	begin
		busClk = 1'b0;
		cycleNA = 1'b1;
		syncWr = 1'b0;
		cmdBits = 9'h000;
		risesSeen = 0;
		romData = 1'b0;
	end

	// Held low while the bus is asynchronous.
	always
	begin
		#62.5;
		busClk = busRun ? ~busClk : 1'b0;
	end

	task automatic sync_cmd(input logic wr);
		@(negedge busClk);
		cycleNA = 1'b0;
		syncWr = wr;
		@(negedge busClk);
		cycleNA = 1'b1;
		syncWr = ~wr;
	endtask

	always @(posedge romClk or negedge romSel)
	begin
		if (!romSel)
			risesSeen <= 0;
		else
		begin
			risesSeen <= risesSeen + 1;
			if (risesSeen < 9)
				cmdBits <= {cmdBits[7:0], romDin};
		end
	end

	// While selected, the data line reads low outside the word; deselected, it carries strapLvl.
	always @(negedge romClk or negedge romSel)
	begin
		if (romSel && risesSeen >= 9 && risesSeen <= 24)
			romData <= ROM_WORD[24 - risesSeen];
		else
			romData <= 1'b0;
	end

	assign romDout = romSel ? romData : strapLvl;
endmodule

//--- bench/host_bus_interface_and_strap_config_tb_top.sv
// Purpose: Self-checking bench for the host bus port.
// Assumes: Loader half period left at 500 system clocks.
// Notes:   Straps are changed through a reset, and in t_straps also after capture.
`timescale 1ns/1ps
module host_bus_interface_and_strap_config_tb_top;
	import hbi_pkg::*;
	localparam logic [15:0] ROM_WORD = 16'ha5c0;
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic [15:1] addrIn = 15'h0000;
	logic        addrQualN = 1'b1;
	logic        addrStrobeN = 1'b1;
	logic        addrLatchEn = 1'b0;
	logic        readStrobeN = 1'b1;
	logic        writeStrobeN = 1'b1;
	logic        busModeStrap = 1'b1;
	logic        cfgRomEnableStrap = 1'b0;
	logic        strapLvl = 1'b0;
	logic        busRun = 1'b0;
	logic [15:0] intStatus = 16'h0000;
	logic        accDone = 1'b0;
	logic        busClk, cycleNA, syncWriteRead, cfgRomSerialIn;
	logic        localDevSelectN, hostIrqO, hostIrqOeN, asyncReadyO;
	logic        asyncReadyOeN, cfgRomSelect, cfgRomSerialClk;
	logic        cfgRomSerialOut, accReq, accWrite, accSync;
	logic        cfgBusSync, cfgRomPresent;
	hbi_width_e  cfgWidth;
	logic [15:0] baseAddr;
	logic [8:0]  cmdBits;
	logic        burstCyc = 1'b1;
	logic        burstReq, burstWr;
	hbi_width_e  burstW;
	int          miscompares = 0;
	int          checkCount = 0;

	always #2 mclk = ~mclk;

	hbi_host_port i_dut (.mclk(mclk), .nrst(nrst), .ce(1'b1),
		.busClk(busClk), .addrIn(addrIn), .addrQualN(addrQualN),
		.addrStrobeN(addrStrobeN), .addrLatchEn(addrLatchEn),
		.readStrobeN(readStrobeN), .writeStrobeN(writeStrobeN),
		.cycleNA(cycleNA), .syncWriteRead(syncWriteRead),
		.busModeStrap(busModeStrap), .cfgRomEnableStrap(cfgRomEnableStrap),
		.cfgRomSerialIn(cfgRomSerialIn), .intStatus(intStatus),
		.accDone(accDone), .baseAddrWe(1'b0), .baseAddrIn(16'h0000),
		.localDevSelectN(localDevSelectN), .hostIrqO(hostIrqO),
		.hostIrqOeN(hostIrqOeN), .asyncReadyO(asyncReadyO),
		.asyncReadyOeN(asyncReadyOeN), .cfgRomSelect(cfgRomSelect),
		.cfgRomSerialClk(cfgRomSerialClk),
		.cfgRomSerialOut(cfgRomSerialOut), .accReq(accReq),
		.accWrite(accWrite), .accSync(accSync), .cfgBusSync(cfgBusSync),
		.cfgWidth(cfgWidth), .cfgRomPresent(cfgRomPresent),
		.baseAddr(baseAddr));

	hbi_far_model #(.ROM_WORD(ROM_WORD)) i_far (.busRun(busRun),
		.strapLvl(strapLvl), .romSel(cfgRomSelect),
		.romClk(cfgRomSerialClk), .romDin(cfgRomSerialOut),
		.busClk(busClk), .cycleNA(cycleNA), .syncWr(syncWriteRead),
		.romDout(cfgRomSerialIn), .cmdBits(cmdBits));

	// A 32-bit build beside the main one, so burst mode is exercised.
	hbi_host_port #(.IS_32BIT(1'b1)) i_dut32 (.mclk(mclk), .nrst(nrst),
		.ce(1'b1), .busClk(1'b0), .addrIn(addrIn), .addrQualN(addrQualN),
		.addrStrobeN(1'b1), .addrLatchEn(1'b0), .readStrobeN(readStrobeN),
		.writeStrobeN(writeStrobeN), .cycleNA(burstCyc),
		.syncWriteRead(1'b0), .busModeStrap(busModeStrap),
		.cfgRomEnableStrap(cfgRomEnableStrap), .cfgRomSerialIn(strapLvl),
		.intStatus(intStatus), .accDone(accDone), .baseAddrWe(1'b0),
		.baseAddrIn(16'h0000), .localDevSelectN(), .hostIrqO(),
		.hostIrqOeN(), .asyncReadyO(), .asyncReadyOeN(),
		.cfgRomSelect(), .cfgRomSerialClk(), .cfgRomSerialOut(),
		.accReq(burstReq), .accWrite(burstWr), .accSync(),
		.cfgBusSync(), .cfgWidth(burstW), .cfgRomPresent(),
		.baseAddr());

	task automatic chk(input string what, input logic [15:0] exp,
		input logic [15:0] got);
		checkCount++;
		if (got !== exp)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic finish_test();
		$display("Checks %0d mismatches %0d", checkCount, miscompares);
		if (miscompares == 0 && checkCount > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic wait_for(input string what, ref logic sig,
		input logic lvl, input int lim);
		int n;
		n = 0;
		while (sig !== lvl && n < lim)
		begin
			@(negedge mclk);
			n++;
		end
		if (sig !== lvl)
		begin
			miscompares++;
			$display("Error %s expected %h seen %h", what, lvl, sig);
			finish_test();
		end
	endtask

	task automatic do_reset(input logic mode, input logic rom, input logic si);
		@(negedge mclk);
		nrst = 1'b0;
		busModeStrap = mode;
		cfgRomEnableStrap = rom;
		strapLvl = si;
		busRun = ~mode;
		repeat (4) @(negedge mclk);
		nrst = 1'b1;
		repeat (6) @(negedge mclk);
	endtask

	task automatic t_straps();
		for (int s = 0; s < 2; s++)
		begin
			do_reset(1'b1, 1'b0, s[0]);
			repeat (2)
			begin
				chk("busSync", 16'h0000, {15'h0, cfgBusSync});
				chk("width", s ? 16'h0001 : 16'h0000, {14'h0, cfgWidth});
				chk("romPresent", 16'h0000, {15'h0, cfgRomPresent});
				chk("romSelect", 16'h0000, {15'h0, cfgRomSelect});
				chk("base", 16'h0300, baseAddr);
				busModeStrap = 1'b0;
				strapLvl = ~s[0];
				repeat (10) @(negedge mclk);
			end
		end
		$display("Test straps done");
	endtask

	task automatic t_select();
		addrIn = {12'h030, 3'h5};
		addrQualN = 1'b0;
		#1 chk("select", 16'h0000, {15'h0, localDevSelectN});
		@(negedge mclk);
		addrQualN = 1'b1;
		#1 chk("select", 16'h0001, {15'h0, localDevSelectN});
		@(negedge mclk);
		addrQualN = 1'b0;
		addrIn = {12'h031, 3'h5};
		#1 chk("select", 16'h0001, {15'h0, localDevSelectN});
		@(negedge mclk);
		addrIn = {12'h030, 3'h0};
		addrLatchEn = 1'b1;
		addrStrobeN = 1'b0;
		@(negedge mclk);
		addrStrobeN = 1'b1;
		repeat (6) @(negedge mclk);
		addrIn = {12'h031, 3'h0};
		#1 chk("latched", 16'h0000, {15'h0, localDevSelectN});
		@(negedge mclk);
		addrLatchEn = 1'b0;
		addrIn = {12'h030, 3'h0};
		@(negedge mclk);
		$display("Test select done");
	endtask

	task automatic t_irq();
		for (int b = 0; b < 16; b += 15)
		begin
			intStatus = 16'h0001 << b;
			repeat (2) @(negedge mclk);
			chk("irqOeN", 16'h0000, {14'h0, hostIrqOeN, hostIrqO});
			intStatus = 16'h0000;
			repeat (2) @(negedge mclk);
			chk("irqOeN", 16'h0002, {14'h0, hostIrqOeN, hostIrqO});
		end
		$display("Test irq done");
	endtask

	task automatic t_async(input logic wr);
		readStrobeN = wr;
		writeStrobeN = ~wr;
		burstCyc = ~wr;
		wait_for("accReq", accReq, 1'b1, 10);
		chk("accWrite", {15'h0, wr}, {15'h0, accWrite});
		chk("burstReq", 16'h0001, {15'h0, burstReq});
		chk("burstWrite", {15'h0, wr}, {15'h0, burstWr});
		chk("burstWidth", 16'h0002, {14'h0, burstW});
		chk("accSync", 16'h0000, {15'h0, accSync});
		repeat (5) @(negedge mclk);
		chk("readyOeN", 16'h0000, {14'h0, asyncReadyOeN, asyncReadyO});
		accDone = 1'b1;
		@(negedge mclk);
		accDone = 1'b0;
		@(negedge mclk);
		chk("readyOeN", 16'h0002, {14'h0, asyncReadyOeN, asyncReadyO});
		readStrobeN = 1'b1;
		writeStrobeN = 1'b1;
		burstCyc = 1'b1;
		repeat (4) @(negedge mclk);
		$display("Test async access done");
	endtask

	task automatic t_refused();
		logic [15:0] seen;
		seen = 16'h0000;
		addrQualN = 1'b1;
		readStrobeN = 1'b0;
		repeat (10)
		begin
			@(negedge mclk);
			seen = seen + {15'h0, accReq};
		end
		chk("refused", 16'h0000, seen);
		readStrobeN = 1'b1;
		addrQualN = 1'b0;
		repeat (4) @(negedge mclk);
		$display("Test refused done");
	endtask

	task automatic t_sync();
		do_reset(1'b0, 1'b0, 1'b0);
		repeat (100) @(negedge mclk);
		chk("busSync", 16'h0001, {15'h0, cfgBusSync});
		for (int w = 0; w < 2; w++)
		begin
			fork
				i_far.sync_cmd(w[0]);
				wait_for("syncReq", accReq, 1'b1, 100);
			join
			chk("syncDir", {14'h0, w[0], 1'b1}, {14'h0, accWrite, accSync});
		end
		$display("Test sync access done");
	endtask

	task automatic t_rom();
		int n;
		n = 0;
		do_reset(1'b1, 1'b1, 1'b0);
		wait_for("romSel", cfgRomSelect, 1'b1, 10);
		wait_for("romClk", cfgRomSerialClk, 1'b1, 1100);
		while (cfgRomSerialClk === 1'b1 && n < 2000)
		begin
			@(negedge mclk);
			n++;
		end
		while (cfgRomSerialClk === 1'b0 && n < 2000)
		begin
			@(negedge mclk);
			n++;
		end
		chk("romPeriod", 16'd1000, n[15:0]);
		wait_for("romDone", cfgRomSelect, 1'b0, 30000);
		repeat (2) @(negedge mclk);
		chk("romCmd", 16'h0180, {7'h0, cmdBits});
		chk("romWord", ROM_WORD, baseAddr);
		chk("romPresent", 16'h0001, {15'h0, cfgRomPresent});
		chk("romWidth", 16'h0001, {14'h0, cfgWidth});
		addrIn = {ROM_WORD[15:4], 3'h0};
		#1 chk("select", 16'h0000, {15'h0, localDevSelectN});
		repeat (2000) @(negedge mclk);
		chk("romIdle", 16'h0000, {14'h0, cfgRomSelect, cfgRomSerialClk});
		$display("Test eeprom done");
	endtask

	initial
	begin
		t_straps();
		do_reset(1'b1, 1'b0, 1'b1);
		t_select();
		t_irq();
		t_async(1'b0);
		t_async(1'b1);
		t_refused();
		t_sync();
		t_rom();
		finish_test();
	end
endmodule
